// [nvs_host.sv]
// Host controller that drives the nonvolatile SRAM pins for reads, writes, stores and recalls.
`timescale 1ns/10ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_host #(
    parameter int unsigned STORE_CYC = `NVS_US_CYC(`NVS_STORE_US),
    parameter int unsigned RESTORE_CYC = `NVS_US_CYC(`NVS_RESTORE_US),
    parameter int unsigned RECALL_CYC = `NVS_US_CYC(`NVS_RECALL_US)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire nvs_pkg::nvs_req_t req,
    output logic req_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic op_done,
    output logic chip_sel_n,
    output logic write_n,
    output logic out_drive_n,
    output logic [14:0] addr,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic [7:0] dq_in,
    output logic store_busy_n_out,
    output logic store_busy_n_oe,
    input wire logic store_busy_n_in
);
    nvs_pkg::nvs_regs_t r;
    nvs_pkg::nvs_regs_t next_r;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic busy_s1;
    logic busy_s2;

    function automatic logic [13:0] seq_addr(input logic [2:0] idx);
        case (idx)
            3'h0: seq_addr = `NVS_SEQ_A0;
            3'h1: seq_addr = `NVS_SEQ_A1;
            3'h2: seq_addr = `NVS_SEQ_A2;
            3'h3: seq_addr = `NVS_SEQ_A3;
            default: seq_addr = `NVS_SEQ_A4;
        endcase
    endfunction : seq_addr

    function automatic logic [`NVS_CNT_W-1:0] cyc(input int unsigned n);
        cyc = `NVS_CNT_W'(n);
    endfunction : cyc

    // Pin inputs come from outside this clock domain.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
            busy_s1 <= 1'b1;
            busy_s2 <= 1'b1;
        end else if (clk_en) begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            busy_s1 <= store_busy_n_in;
            busy_s2 <= busy_s1;
        end
    end

    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        next_r.done = 1'b0;
        if (r.cnt != '0) begin
            next_r.cnt = r.cnt - 1'b1;
        end
        case (r.st)
            // Power-up recall runs with the memory deselected and the strobe high.
            nvs_pkg::NVS_POWERUP: begin
                next_r.pins.chip_sel_n = 1'b1;
                next_r.pins.write_n = 1'b1;
                if (r.cnt == '0) begin
                    next_r.st = nvs_pkg::NVS_IDLE;
                    next_r.ready = 1'b1;
                end
            end
            nvs_pkg::NVS_IDLE: begin
                if (req_valid && r.ready) begin
                    next_r.ready = 1'b0;
                    next_r.pins.addr = req.addr;
                    next_r.step = 3'h0;
                    next_r.was_sw_store = 1'b0;
                    case (req.cmd)
                        nvs_pkg::NVS_CMD_WRITE: begin
                            // Output-drive stays high so the bus never contends.
                            next_r.pins.out_drive_n = 1'b1;
                            next_r.pins.dq_out = req.wdata;
                            next_r.pins.dq_oe = 1'b1;
                            next_r.pins.write_n = 1'b0;
                            next_r.last = 1'b1;
                            next_r.st = nvs_pkg::NVS_SETUP;
                        end
                        nvs_pkg::NVS_CMD_SW_STORE, nvs_pkg::NVS_CMD_SW_RECALL: begin
                            next_r.pins.addr = {1'b0, seq_addr(3'h0)};
                            next_r.pins.out_drive_n = 1'b1;
                            next_r.final_addr = (req.cmd == nvs_pkg::NVS_CMD_SW_STORE) ?
                                `NVS_SEQ_STORE : `NVS_SEQ_RECALL;
                            next_r.was_sw_store = (req.cmd == nvs_pkg::NVS_CMD_SW_STORE);
                            next_r.last = 1'b0;
                            next_r.st = nvs_pkg::NVS_SETUP;
                        end
                        nvs_pkg::NVS_CMD_HW_STORE: begin
                            next_r.pins.busy_out = 1'b0;
                            next_r.pins.busy_oe = 1'b1;
                            next_r.cnt = cyc(`NVS_PULSE_CYC);
                            next_r.st = nvs_pkg::NVS_HW_PULSE;
                        end
                        default: begin
                            next_r.pins.out_drive_n = 1'b0;
                            next_r.last = 1'b1;
                            next_r.st = nvs_pkg::NVS_SETUP;
                        end
                    endcase
                end
            end
            // Address is set one cycle before select falls and held past its rise.
            nvs_pkg::NVS_SETUP: begin
                if (!busy_s2) begin
                    next_r.st = nvs_pkg::NVS_WAIT_DONE;
                    next_r.pins.dq_oe = 1'b0;
                    next_r.pins.write_n = 1'b1;
                    next_r.pins.out_drive_n = 1'b1;
                end else begin
                    next_r.pins.chip_sel_n = 1'b0;
                    next_r.cnt = cyc(`NVS_ACCESS_CYC);
                    next_r.st = nvs_pkg::NVS_STROBE;
                end
            end
            nvs_pkg::NVS_STROBE: begin
                if (r.cnt == '0) begin
                    next_r.pins.chip_sel_n = 1'b1;
                    next_r.rdata = dq_s2;
                    next_r.st = nvs_pkg::NVS_HOLD;
                end
            end
            nvs_pkg::NVS_HOLD: begin
                next_r.pins.write_n = 1'b1;
                next_r.pins.dq_oe = 1'b0;
                next_r.pins.out_drive_n = 1'b1;
                if (r.last && r.step == 3'h0) begin
                    // Only a read holds output-drive low, so a write ends without a data pulse.
                    next_r.rvalid = !r.pins.out_drive_n;
                    next_r.done = 1'b1;
                    next_r.ready = 1'b1;
                    next_r.st = nvs_pkg::NVS_IDLE;
                end else if (r.last) begin
                    // The sixth read launched the command; wait out its duration.
                    next_r.cnt = r.was_sw_store ? cyc(STORE_CYC) : cyc(RECALL_CYC);
                    next_r.st = nvs_pkg::NVS_RECOVER;
                end else begin
                    // Sequence reads follow back to back with nothing between them.
                    next_r.step = r.step + 3'h1;
                    next_r.last = (r.step == 3'h4);
                    next_r.pins.addr = (r.step == 3'h4) ? {1'b0, r.final_addr} :
                        {1'b0, seq_addr(r.step + 3'h1)};
                    next_r.st = nvs_pkg::NVS_SETUP;
                end
            end
            nvs_pkg::NVS_HW_PULSE: begin
                if (r.cnt == '0) begin
                    next_r.pins.busy_oe = 1'b0;
                    next_r.pins.busy_out = 1'b1;
                    next_r.cnt = cyc(`NVS_BUSY_WAIT_CYC);
                    next_r.st = nvs_pkg::NVS_HW_WAIT_BUSY;
                end
            end
            // No busy from the device means no store was needed.
            nvs_pkg::NVS_HW_WAIT_BUSY: begin
                if (!busy_s2) begin
                    next_r.st = nvs_pkg::NVS_WAIT_DONE;
                end else if (r.cnt == '0) begin
                    next_r.cnt = cyc(`NVS_RECOVER_CYC);
                    next_r.st = nvs_pkg::NVS_RECOVER;
                end
            end
            // Busy may stay low up to the full store duration.
            nvs_pkg::NVS_WAIT_DONE: begin
                if (busy_s2) begin
                    next_r.cnt = cyc(`NVS_RECOVER_CYC);
                    next_r.st = nvs_pkg::NVS_RECOVER;
                end
            end
            nvs_pkg::NVS_RECOVER: begin
                if (!busy_s2) begin
                    next_r.st = nvs_pkg::NVS_WAIT_DONE;
                end else if (r.cnt == '0) begin
                    next_r.done = 1'b1;
                    next_r.ready = 1'b1;
                    next_r.st = nvs_pkg::NVS_IDLE;
                end
            end
            default: next_r.st = nvs_pkg::NVS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '0;
            r.st <= nvs_pkg::NVS_POWERUP;
            r.pins.chip_sel_n <= 1'b1;
            r.pins.write_n <= 1'b1;
            r.pins.out_drive_n <= 1'b1;
            r.pins.busy_out <= 1'b1;
            r.cnt <= `NVS_CNT_W'(RESTORE_CYC);
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign req_ready = r.ready;
    assign rd_data = r.rdata;
    assign rd_valid = r.rvalid;
    assign op_done = r.done;
    assign chip_sel_n = r.pins.chip_sel_n;
    assign write_n = r.pins.write_n;
    assign out_drive_n = r.pins.out_drive_n;
    assign addr = r.pins.addr;
    assign dq_out = r.pins.dq_out;
    assign dq_oe = r.pins.dq_oe;
    assign store_busy_n_out = r.pins.busy_out;
    assign store_busy_n_oe = r.pins.busy_oe;
endmodule : nvs_host
`default_nettype wire

// [nvs_cfg.svh]
// Timing and command constants for the nonvolatile SRAM host controller.
// Functional notes
// - Host holds address stable through write.
// - Host keeps output-drive high during writes.
// - Store request pulse at least 15 ns.
// - Host must not write when recall ends.
// - Six reads trigger software store.
// - Five reads plus 0C63 trigger recall, 20 us.
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH
`define NVS_CLK_MHZ 25
`define NVS_NS_PER_CYC 40
`define NVS_STORE_PULSE_NS 80
`define NVS_PULSE_CYC ((`NVS_STORE_PULSE_NS + `NVS_NS_PER_CYC - 1) / `NVS_NS_PER_CYC)
`define NVS_BUSY_WAIT_NS 300
`define NVS_BUSY_WAIT_CYC ((`NVS_BUSY_WAIT_NS + `NVS_NS_PER_CYC - 1) / `NVS_NS_PER_CYC)
`define NVS_RECOVER_NS 700
`define NVS_RECOVER_CYC ((`NVS_RECOVER_NS + `NVS_NS_PER_CYC - 1) / `NVS_NS_PER_CYC)
`define NVS_STORE_US 10000
`define NVS_RECALL_US 20
`define NVS_RESTORE_US 550
`define NVS_US_CYC(us) ((us) * `NVS_CLK_MHZ)
`define NVS_ACCESS_CYC 2
`define NVS_SEQ_A0 14'h0e38
`define NVS_SEQ_A1 14'h31c7
`define NVS_SEQ_A2 14'h03e0
`define NVS_SEQ_A3 14'h3c1f
`define NVS_SEQ_A4 14'h303f
`define NVS_SEQ_STORE 14'h0fc0
`define NVS_SEQ_RECALL 14'h0c63
`define NVS_CNT_W 20
`endif

// [nvs_pkg.sv]
// Types for the nonvolatile SRAM host controller.
`default_nettype none
`include "nvs_cfg.svh"
package nvs_pkg;
    typedef enum logic [2:0] {
        NVS_CMD_READ,
        NVS_CMD_WRITE,
        NVS_CMD_SW_STORE,
        NVS_CMD_SW_RECALL,
        NVS_CMD_HW_STORE
    } nvs_cmd_t;

    typedef struct packed {
        nvs_cmd_t cmd;
        logic [14:0] addr;
        logic [7:0] wdata;
    } nvs_req_t;

    typedef struct packed {
        logic chip_sel_n;
        logic write_n;
        logic out_drive_n;
        logic [14:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
        logic busy_out;
        logic busy_oe;
    } nvs_pins_t;

    typedef enum {
        NVS_IDLE,
        NVS_SETUP,
        NVS_STROBE,
        NVS_HOLD,
        NVS_HW_PULSE,
        NVS_HW_WAIT_BUSY,
        NVS_WAIT_DONE,
        NVS_RECOVER,
        NVS_POWERUP
    } nvs_state_t;

    typedef struct packed {
        nvs_state_t st;
        nvs_pins_t pins;
        logic [2:0] step;
        logic last;
        logic [13:0] final_addr;
        logic [`NVS_CNT_W-1:0] cnt;
        logic [7:0] rdata;
        logic rvalid;
        logic ready;
        logic done;
        logic was_sw_store;
    } nvs_regs_t;
endpackage : nvs_pkg
`default_nettype wire

// [nvs_host_chk.sv]
// Checker that watches the host controller pins of the nonvolatile SRAM.
`timescale 1ns/10ps
`default_nettype none
module nvs_host_chk #(
    parameter int unsigned RESTORE_CYC = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_ready,
    input wire logic rd_valid,
    input wire logic op_done,
    input wire logic chip_sel_n,
    input wire logic write_n,
    input wire logic out_drive_n,
    input wire logic [14:0] addr,
    input wire logic dq_oe,
    input wire logic store_busy_n_out,
    input wire logic store_busy_n_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    int unsigned since_rst;
    // Counts from reset release so that the power-up recall wait can be judged.
    always_ff @(posedge sys_clk) begin
        since_rst <= rst ? 0 : since_rst + 1;
    end
    sequence strobe_s;
        chip_sel_n ##1 !chip_sel_n [*3] ##1 chip_sel_n;
    endsequence
    chk_write_walk: assert property ($fell(write_n) |-> strobe_s ##0 !write_n ##1 write_n)
        else $error("write strobe walk broken");
    chk_read_end: assert property (rd_valid |-> op_done && !$past(out_drive_n) && !$past(chip_sel_n, 2))
        else $error("read ended without a selected read");
    chk_addr_hold: assert property (!write_n && !$past(write_n) |-> $stable(addr))
        else $error("address moved during write");
    chk_oe_write: assert property (!write_n |-> out_drive_n && dq_oe)
        else $error("output drive low during write");
    chk_pulse_hold: assert property ($rose(store_busy_n_oe) |-> !store_busy_n_out ##1 store_busy_n_oe)
        else $error("store request pulse too short");
    chk_idle_quiet: assert property (req_ready |-> chip_sel_n && write_n && !dq_oe && !store_busy_n_oe)
        else $error("pins busy while idle");
    chk_recall_wait: assert property (req_ready |-> since_rst + 1 >= RESTORE_CYC)
        else $error("ready before power-up recall ended");
    chk_seq_reads: assert property (!chip_sel_n && !dq_oe |-> write_n)
        else $error("strobe low in a select without data");
endmodule : nvs_host_chk
bind nvs_host nvs_host_chk #(.RESTORE_CYC(RESTORE_CYC)) i_nvs_host_chk (
    .sys_clk(sys_clk), .rst(rst), .req_ready(req_ready), .rd_valid(rd_valid), .op_done(op_done),
    .chip_sel_n(chip_sel_n), .write_n(write_n), .out_drive_n(out_drive_n), .addr(addr), .dq_oe(dq_oe),
    .store_busy_n_out(store_busy_n_out), .store_busy_n_oe(store_busy_n_oe)
);
`default_nettype wire

// [nvs_mem_model.sv]
// Behavioural model of the nonvolatile SRAM seen from its pins.
`timescale 1ns/10ps
`default_nettype none
module nvs_mem_model #(
    parameter int DUR = 10
) (
    input wire logic clk,
    input wire logic chip_sel_n,
    input wire logic write_n,
    input wire logic out_drive_n,
    input wire logic [14:0] addr,
    input wire logic [7:0] dq_host,
    input wire logic busy_wire,
    output logic [7:0] dq_dev,
    output logic dev_pull,
    output int n_stores
);
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    logic [13:0] seq [0:4] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
    logic [7:0] last = 8'h00;
    logic dirty = 1'b0;
    int cnt = DUR;
    int mode = 2;
    int sw_req = 0;
    int step = 0;
    wire quiet = cnt == 0 && busy_wire;
    wire rd = !chip_sel_n && !out_drive_n && write_n && quiet;
    // Undriven data lines show the inverse of the last byte so stale data never matches.
    assign dq_dev = rd ? mem[addr] : ~last;
    assign dev_pull = cnt != 0 && mode == 1;
    initial n_stores = 0;
    task automatic end_write;
        if (quiet) begin
            mem[addr] = dq_host;
            dirty = 1'b1;
        end
        step = 0;
    endtask : end_write
    always @(posedge write_n) if (!chip_sel_n) end_write();
    always @(posedge chip_sel_n) begin
        if (!write_n) end_write();
        else if (quiet) begin
            if (step == 5 && addr[13:0] == 14'h0fc0) sw_req = 1;
            if (step == 5 && addr[13:0] == 14'h0c63) sw_req = 2;
            if (step < 5 && addr[13:0] == seq[step]) step++;
            else step = int'(addr[13:0] == seq[0]);
        end
    end
    always @(posedge clk) begin
        if (rd) last <= mem[addr];
        // The snapshot is taken at the end of the window, so a cycle in progress has landed first.
        if (cnt == 1 && mode == 1) begin
            nv = mem;
            n_stores++;
            dirty = 1'b0;
        end
        if (cnt == 1 && mode == 2) begin
            mem = nv;
            dirty = 1'b0;
        end
        // Counter and mode move by non-blocking assignment so the busy pull never races the host's sampling.
        if (cnt > 0) cnt <= cnt - 1;
        else if (sw_req != 0) begin
            mode <= sw_req;
            cnt <= DUR;
            sw_req = 0;
        end else if (!busy_wire && dirty) begin
            mode <= 1;
            cnt <= DUR;
        end
    end
endmodule : nvs_mem_model
`default_nettype wire

// [nvs_host_test.sv]
// Self-checking bench for the nonvolatile SRAM host controller.
`timescale 1ns/10ps
`default_nettype none
module nvs_host_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    nvs_pkg::nvs_req_t req = '0;
    logic req_ready, rd_valid, op_done, chip_sel_n, write_n, out_drive_n, dq_oe, busy_out, busy_oe, dev_pull;
    logic [7:0] rd_data, dq_out, dq_dev;
    logic [14:0] addr;
    int n_stores;
    int n_errors = 0;
    int n_compared = 0;
    logic [7:0] mirror [int];
    logic [7:0] shadow [int];
    wire busy_wire = !((busy_oe && !busy_out) || dev_pull);
    always #20 sys_clk = ~sys_clk;
    nvs_host #(.STORE_CYC(20), .RESTORE_CYC(20), .RECALL_CYC(20)) i_nvs_host (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .op_done(op_done),
        .chip_sel_n(chip_sel_n), .write_n(write_n), .out_drive_n(out_drive_n), .addr(addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_oe ? dq_out : dq_dev), .store_busy_n_out(busy_out),
        .store_busy_n_oe(busy_oe), .store_busy_n_in(busy_wire));
    nvs_mem_model #(.DUR(10)) i_nvs_mem_model (
        .clk(sys_clk), .chip_sel_n(chip_sel_n), .write_n(write_n), .out_drive_n(out_drive_n), .addr(addr),
        .dq_host(dq_out), .busy_wire(busy_wire), .dq_dev(dq_dev), .dev_pull(dev_pull), .n_stores(n_stores));
    task automatic end_of_test;
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [7:0] exp_byte(int a);
        return mirror[a];
    endfunction : exp_byte
    task automatic run(nvs_pkg::nvs_cmd_t cmd, logic [14:0] a, logic [7:0] d);
        int i;
        for (i = 0; i < 300 && req_ready !== 1'b1; i++) @(posedge sys_clk) #1;
        req = '{cmd: cmd, addr: a, wdata: d};
        req_valid = 1'b1;
        @(posedge sys_clk) #1;
        req_valid = 1'b0;
        for (i = 0; i < 700 && op_done !== 1'b1; i++) @(posedge sys_clk) #1;
        check("op_done", 8'(op_done), 8'h01);
        check("rd_valid", 8'(rd_valid), 8'(cmd == nvs_pkg::NVS_CMD_READ));
        // A short freeze between operations, never while a done pulse stands.
        @(posedge sys_clk) #1;
        clk_en = 1'($urandom);
        @(posedge sys_clk) #1;
        clk_en = 1'b1;
    endtask : run
    task automatic read_all;
        foreach (mirror[k]) begin
            run(nvs_pkg::NVS_CMD_READ, 15'(k), 8'h00);
            check("read data", rd_data, exp_byte(k));
        end
    endtask : read_all
    initial begin
        #2000000;
        n_errors++;
        end_of_test();
    end
    initial begin
        int i;
        logic [14:0] a;
        void'($urandom(4017));
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        for (i = 0; i < 8; i++) begin
            a = i == 0 ? 15'h7fff : (i == 1 ? 15'h0000 : 15'($urandom));
            mirror[a] = 8'($urandom);
            run(nvs_pkg::NVS_CMD_WRITE, a, mirror[a]);
        end
        read_all();
        run(nvs_pkg::NVS_CMD_HW_STORE, 15'h0000, 8'h00);
        check("store count", 8'(n_stores), 8'h01);
        shadow = mirror;
        run(nvs_pkg::NVS_CMD_HW_STORE, 15'h0000, 8'h00);
        check("store count", 8'(n_stores), 8'h01);
        run(nvs_pkg::NVS_CMD_SW_STORE, 15'h0000, 8'h00);
        check("store count", 8'(n_stores), 8'h02);
        foreach (mirror[k]) begin
            mirror[k] = 8'($urandom);
            run(nvs_pkg::NVS_CMD_WRITE, 15'(k), mirror[k]);
        end
        read_all();
        run(nvs_pkg::NVS_CMD_SW_RECALL, 15'h0000, 8'h00);
        mirror = shadow;
        read_all();
        check("store count", 8'(n_stores), 8'h02);
        end_of_test();
    end
endmodule : nvs_host_test
`default_nettype wire
